// >>> inc/assa_pkg.sv
package assa_pkg;
  // ***************************************************
  // Register map (byte addresses, one word each)
  // ***************************************************
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] SWT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] QUEUE_OFS = 8'h0c;
  localparam logic [7:0] SLOT_BASE_OFS = 8'h20;
  // ***************************************************
  // Field positions and values
  // ***************************************************
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_REPEAT_BIT = 2;
  localparam int CFG_TRIG_LSB = 4;
  localparam int CFG_REF_EXT_BIT = 8;
  localparam int CFG_REF_LOW_BIT = 9;
  localparam int SLOT_EN_BIT = 0;
  localparam int SLOT_WCMP_BIT = 1;
  localparam int SLOT_PREC_LSB = 8;
  localparam int SLOT_CHAN_LSB = 16;
  localparam int SLOT_ACC_LSB = 24;
  localparam int QUEUE_CNT_LSB = 20;
  localparam int QUEUE_SLOT_LSB = 28;
  localparam logic [7:0] SWT_KEY = 8'h37;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SLOT_RESET = 32'h0000_0000;
  localparam logic [4:0] QUEUE_DEPTH = 5'h10;
  localparam logic [4:0] QUEUE_THREE_QUARTER = 5'h0c;
  localparam logic [4:0] QUEUE_HALF = 5'h08;
  localparam int SAMPLE_BITS = 14;
  localparam int ACC_BITS = 21;
  localparam int RESULT_BITS = 20;
  // Trigger source codes
  localparam logic [2:0] TRIG_VCOMP = 3'h4;
  localparam logic [2:0] TRIG_FIRMWARE = 3'h7;
  typedef enum logic [1:0] {
    ASSA_IDLE = 2'b00,
    ASSA_PICK = 2'b01,
    ASSA_CONV = 2'b10
  } assa_state_e;
endpackage : assa_pkg

// >>> rtl/assa_top.sv
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
module assa_top #(
  parameter int NUM_SLOTS = 8,
  parameter int QUEUE_ENTRIES = 16
) (
  input wire logic clk_in, // Core clock, 100 MHz
  input wire logic rst_b_in, // Asynchronous reset, active low
  input wire logic [7:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read strobe
  input wire logic avs_write_in, // Write strobe
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Stall
  input wire logic [3:0] pin_trigger_in, // pin_trigger_zero..three
  input wire logic vcomp_trigger_in, // Voltage comparator trigger
  input wire logic timer3_tick_in, // Repeat tick from timer three
  output logic conv_start_out, // Start one conversion
  output logic [3:0] conv_channel_out, // Analog mux select
  output logic [1:0] conv_precision_out, // 0:14 1:12 2:10 3:8 bit
  output logic conv_ref_external_out, // Reference source external
  output logic conv_ref_low_out, // Reference at 1.5V level
  input wire logic conv_done_in, // Sample valid pulse
  input wire logic [13:0] conv_data_in, // Sample, right aligned
  output logic conv_complete_out, // Result written pulse
  output logic scan_busy_out // Scan in progress
);
  // ***************************************************
  // Registers and bus
  // ***************************************************
  logic [31:0] cfg_reg;
  logic [31:0] slot_cfg_reg [NUM_SLOTS];
  logic [20:0] acc_reg [NUM_SLOTS];
  logic [7:0] acc_cnt_reg [NUM_SLOTS];
  logic [27:0] queue_reg [QUEUE_ENTRIES];
  logic [3:0] rd_ptr_reg;
  logic [3:0] wr_ptr_reg;
  logic [4:0] count_reg;
  logic queue_three_quarter_flag_reg;
  logic queue_half_flag_reg;
  logic ack_reg;
  logic [31:0] avs_readdata_reg;
  logic sw_trig;
  logic pop;
  logic push;
  logic wr_acc;
  logic rd_acc;

  // Every access takes one wait cycle, answered on the second edge
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
  assign wr_acc = avs_write_in & ~avs_waitrequest_out;
  // Read data loads in the wait cycle so it stands when waitrequest drops
  assign rd_acc = avs_read_in & ~ack_reg;
  assign avs_readdata_out = avs_readdata_reg;

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
    end
  end

  // Configuration register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_reg <= assa_pkg::CFG_RESET;
    end else if (wr_acc && avs_address_in == assa_pkg::CFG_OFS) begin
      cfg_reg <= lane_merge(cfg_reg, avs_writedata_in, avs_byteenable_in);
    end
  end

  // Per-slot configuration, each slot independent
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot_cfg
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          slot_cfg_reg[gs] <= assa_pkg::SLOT_RESET;
        end else if (wr_acc && avs_address_in ==
                     assa_pkg::SLOT_BASE_OFS + 8'(gs * 4)) begin
          slot_cfg_reg[gs] <= lane_merge(slot_cfg_reg[gs], avs_writedata_in,
                                         avs_byteenable_in);
        end
      end
    end
  endgenerate

  // Firmware trigger key and queue pop, both write side effects
  assign sw_trig = wr_acc && avs_address_in == assa_pkg::SWT_OFS &&
                   avs_writedata_in[7:0] == assa_pkg::SWT_KEY;
  assign pop = wr_acc && avs_address_in == assa_pkg::QUEUE_OFS &&
               count_reg != 5'h00;

  // Read mux; reading the queue has no side effect, unmapped reads zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_reg <= 32'h0000_0000;
    end else if (rd_acc) begin
      avs_readdata_reg <= 32'h0000_0000;
      if (avs_address_in == assa_pkg::CFG_OFS) begin
        avs_readdata_reg <= cfg_reg;
      end else if (avs_address_in == assa_pkg::STAT_OFS) begin
        avs_readdata_reg <= {27'h0, count_reg == assa_pkg::QUEUE_DEPTH, scan_busy_out,
                             queue_three_quarter_flag_reg, queue_half_flag_reg, 1'b0};
      end else if (avs_address_in == assa_pkg::QUEUE_OFS) begin
        avs_readdata_reg <= {1'b0, queue_reg[rd_ptr_reg][27:20], 3'h0,
                             queue_reg[rd_ptr_reg][19:0]};
        avs_readdata_reg[assa_pkg::QUEUE_CNT_LSB +: 8] <= {3'h0, count_reg};
        avs_readdata_reg[assa_pkg::QUEUE_SLOT_LSB +: 3] <= queue_reg[rd_ptr_reg][22:20];
      end else if (avs_address_in >= assa_pkg::SLOT_BASE_OFS &&
                   avs_address_in < assa_pkg::SLOT_BASE_OFS + 8'(NUM_SLOTS * 4)) begin
        avs_readdata_reg <= slot_cfg_reg[3'(avs_address_in[4:2])];
      end
    end
  end

  // ***************************************************
  // Trigger qualification
  // ***************************************************
  logic [4:0] trig_s1_reg;
  logic [4:0] trig_s2_reg;
  logic [4:0] trig_s3_reg;
  logic [4:0] trig_lvl_reg;
  logic [2:0] trig_sel;
  logic sel_level;
  logic hw_trig;
  logic repeat_armed_reg;
  logic scan_req;

  // Three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_s1_reg <= 5'h00;
      trig_s2_reg <= 5'h00;
      trig_s3_reg <= 5'h00;
      trig_lvl_reg <= 5'h00;
    end else begin
      trig_s1_reg <= {vcomp_trigger_in, pin_trigger_in};
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      for (int i = 0; i < 5; i++) begin
        if (trig_s2_reg[i] == trig_s3_reg[i]) begin
          trig_lvl_reg[i] <= trig_s3_reg[i];
        end
      end
    end
  end

  assign trig_sel = cfg_reg[assa_pkg::CFG_TRIG_LSB +: 3];

  // Source decode; reserved and firmware codes select no pin
  always_comb begin
    sel_level = 1'b0;
    if (trig_sel <= 3'h3) begin
      sel_level = trig_lvl_reg[trig_sel[1:0]];
    end else if (trig_sel == assa_pkg::TRIG_VCOMP) begin
      sel_level = trig_lvl_reg[4];
    end
  end

  // Edge detect on the settled level; polarity picks falling vs rising
  logic sel_level_d_reg;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_level_d_reg <= 1'b0;
    end else begin
      sel_level_d_reg <= sel_level;
    end
  end
  assign hw_trig = (trig_sel != assa_pkg::TRIG_FIRMWARE) &&
                   (cfg_reg[assa_pkg::CFG_POL_BIT] ? (sel_level_d_reg & ~sel_level)
                                                  : (sel_level & ~sel_level_d_reg));

  // Repeat mode arms on a firmware trigger, then follows timer three
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      repeat_armed_reg <= 1'b0;
    end else if (!cfg_reg[assa_pkg::CFG_REPEAT_BIT] || !cfg_reg[assa_pkg::CFG_ENABLE_BIT]) begin
      repeat_armed_reg <= 1'b0;
    end else if (sw_trig) begin
      repeat_armed_reg <= 1'b1;
    end
  end

  assign scan_req = cfg_reg[assa_pkg::CFG_ENABLE_BIT] &&
                    (sw_trig || hw_trig || (repeat_armed_reg && timer3_tick_in));

  // ***************************************************
  // Mode controller
  // ***************************************************
  assa_pkg::assa_state_e state_reg;
  logic [2:0] slot_idx_reg;
  logic pend_reg;
  logic [31:0] cur_cfg;
  logic last_sample;
  logic [20:0] acc_sum;
  logic [19:0] scaled;
  logic [2:0] acc_exp;
  logic held_reg;
  logic [13:0] held_data_reg;
  logic sample_valid;
  logic [13:0] sample_now;

  // A final sample refused by a full queue is parked, not lost
  assign sample_valid = conv_done_in | held_reg;
  assign sample_now = held_reg ? held_data_reg : conv_data_in;
  assign cur_cfg = slot_cfg_reg[slot_idx_reg];
  assign acc_exp = cur_cfg[assa_pkg::SLOT_ACC_LSB +: 3];
  assign acc_sum = acc_reg[slot_idx_reg] + 21'(sample_now);
  assign last_sample = (acc_cnt_reg[slot_idx_reg] + 8'h01) == (8'h01 << acc_exp);
  assign scan_busy_out = state_reg != assa_pkg::ASSA_IDLE;
  assign conv_channel_out = cur_cfg[assa_pkg::SLOT_CHAN_LSB +: 4];
  assign conv_precision_out = cur_cfg[assa_pkg::SLOT_PREC_LSB +: 2];
  assign conv_ref_external_out = cfg_reg[assa_pkg::CFG_REF_EXT_BIT];
  assign conv_ref_low_out = cfg_reg[assa_pkg::CFG_REF_LOW_BIT];

  // Scale to 14.6: shift by 6 minus exponent; 128 drops the lsb
  always_comb begin
    if (acc_exp == 3'h7) begin
      scaled = acc_sum[20:1];
    end else begin
      scaled = 20'(acc_sum << (3'h6 - acc_exp));
    end
  end

  // Result only written when the queue has room; otherwise it waits
  assign push = state_reg == assa_pkg::ASSA_CONV && sample_valid && last_sample &&
                count_reg != assa_pkg::QUEUE_DEPTH;

  // Parked sample waits for room; the converter answers only once per start
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      held_reg <= 1'b0;
      held_data_reg <= 14'h0000;
    end else if (push) begin
      held_reg <= 1'b0;
    end else if (state_reg == assa_pkg::ASSA_CONV && conv_done_in && last_sample) begin
      held_reg <= 1'b1;
      held_data_reg <= conv_data_in;
    end
  end

  // A trigger during a scan is kept and serviced when it ends
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= assa_pkg::ASSA_IDLE;
      slot_idx_reg <= 3'h0;
      pend_reg <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      if (scan_req && state_reg != assa_pkg::ASSA_IDLE) begin
        pend_reg <= 1'b1;
      end
      case (state_reg)
        assa_pkg::ASSA_IDLE: begin
          if (scan_req || pend_reg) begin
            pend_reg <= 1'b0;
            slot_idx_reg <= 3'h0;
            state_reg <= assa_pkg::ASSA_PICK;
          end
        end
        assa_pkg::ASSA_PICK: begin
          if (cur_cfg[assa_pkg::SLOT_EN_BIT]) begin
            conv_start_out <= 1'b1;
            state_reg <= assa_pkg::ASSA_CONV;
          end else if (slot_idx_reg == 3'(NUM_SLOTS - 1)) begin
            state_reg <= assa_pkg::ASSA_IDLE;
          end else begin
            slot_idx_reg <= slot_idx_reg + 3'h1;
          end
        end
        assa_pkg::ASSA_CONV: begin
          // A full queue stalls the final sample until space appears
          if (sample_valid && (!last_sample || push)) begin
            if (slot_idx_reg == 3'(NUM_SLOTS - 1)) begin
              state_reg <= assa_pkg::ASSA_IDLE;
            end else begin
              slot_idx_reg <= slot_idx_reg + 3'h1;
              state_reg <= assa_pkg::ASSA_PICK;
            end
          end
        end
        default: state_reg <= assa_pkg::ASSA_IDLE;
      endcase
    end
  end

  // Accumulators and sample counts, one set per slot
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_acc
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          acc_reg[gs] <= 21'h000000;
          acc_cnt_reg[gs] <= 8'h00;
        end else if (!cfg_reg[assa_pkg::CFG_ENABLE_BIT]) begin
          acc_reg[gs] <= 21'h000000;
          acc_cnt_reg[gs] <= 8'h00;
        end else if (state_reg == assa_pkg::ASSA_CONV && sample_valid &&
                     slot_idx_reg == 3'(gs)) begin
          if (!last_sample) begin
            acc_reg[gs] <= acc_sum;
            acc_cnt_reg[gs] <= acc_cnt_reg[gs] + 8'h01;
          end else if (push) begin
            acc_reg[gs] <= 21'h000000;
            acc_cnt_reg[gs] <= 8'h00;
          end
        end
      end
    end
  endgenerate

  // ***************************************************
  // Result queue
  // ***************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < QUEUE_ENTRIES; i++) begin
        queue_reg[i] <= 28'h0000000;
      end
    end else if (push) begin
      queue_reg[wr_ptr_reg] <= {5'h00, slot_idx_reg, scaled};
    end
  end

  // Pointers and live count; disabling the block empties the queue
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_ptr_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
      count_reg <= 5'h00;
      conv_complete_out <= 1'b0;
    end else if (!cfg_reg[assa_pkg::CFG_ENABLE_BIT]) begin
      rd_ptr_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
      count_reg <= 5'h00;
      conv_complete_out <= 1'b0;
    end else begin
      conv_complete_out <= push;
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      count_reg <= count_reg + {4'h0, push} - {4'h0, pop};
    end
  end

  // Fill flags; set wins over a same-cycle clear by a status write
  logic [4:0] count_after;
  logic stat_clr;
  assign count_after = count_reg + 5'h01 - {4'h0, pop};
  assign stat_clr = wr_acc && avs_address_in == assa_pkg::STAT_OFS;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      queue_three_quarter_flag_reg <= 1'b0;
      queue_half_flag_reg <= 1'b0;
    end else begin
      if (push && count_after == assa_pkg::QUEUE_THREE_QUARTER) begin
        queue_three_quarter_flag_reg <= 1'b1;
      end else if (stat_clr && avs_writedata_in[2]) begin
        queue_three_quarter_flag_reg <= 1'b0;
      end
      if (push && count_after == assa_pkg::QUEUE_HALF) begin
        queue_half_flag_reg <= 1'b1;
      end else if (stat_clr && avs_writedata_in[1]) begin
        queue_half_flag_reg <= 1'b0;
      end
    end
  end
endmodule : assa_top

// >>> tb/assa_conv_model.sv
`timescale 1ns/10ps
// ***************************************************
// Converter core stand-in
// ***************************************************
module assa_conv_model (
  input wire logic clk_in, // Core clock
  input wire logic rst_b_in, // Async reset, active low
  input wire logic conv_start_in, // Start one conversion
  input wire logic slow_in, // Answer late when high
  input wire logic [13:0] sample_in, // Value to return
  output logic conv_done_out, // Sample valid pulse
  output logic [13:0] conv_data_out // Sample, right aligned
);
  logic [3:0] wait_reg;
  // One answer per start; data toggles outside the done cycle so stale reads show
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_reg <= 4'h0;
      conv_done_out <= 1'b0;
      conv_data_out <= 14'h0000;
    end else begin
      conv_done_out <= (wait_reg == 4'h1);
      conv_data_out <= (wait_reg == 4'h1) ? sample_in : ~conv_data_out;
      if (conv_start_in) begin
        wait_reg <= slow_in ? 4'h6 : 4'h1;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule : assa_conv_model

// >>> tb/assa_top_properties.sv
`timescale 1ns/10ps
// ***************************************************
// Port checker
// ***************************************************
module assa_top_checker (
  input wire logic clk_in, // Core clock
  input wire logic rst_b_in, // Async reset, active low
  input wire logic [7:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read strobe
  input wire logic avs_write_in, // Write strobe
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  input wire logic [31:0] avs_readdata_out, // Read data
  input wire logic avs_waitrequest_out, // Stall
  input wire logic conv_start_out, // Conversion start
  input wire logic conv_ref_external_out, // Reference external
  input wire logic conv_ref_low_out, // Reference low level
  input wire logic conv_complete_out, // Result written
  input wire logic scan_busy_out // Scan running
);
  logic req;
  logic done_acc;
  logic cfg_en_reg;
  assign req = avs_read_in | avs_write_in;
  assign done_acc = req & ~avs_waitrequest_out;
  // Enable mirror; a disabled block is allowed to ignore triggers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_en_reg <= 1'b0;
    end else if (avs_write_in && done_acc && avs_address_in == assa_pkg::CFG_OFS
                 && avs_byteenable_in[0]) begin
      cfg_en_reg <= avs_writedata_in[assa_pkg::CFG_ENABLE_BIT];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wait_state_a: assert property ($rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus answer not after one wait state");
  swt_starts_scan_a: assert property (cfg_en_reg && avs_write_in && done_acc
    && avs_address_in == assa_pkg::SWT_OFS && avs_writedata_in[7:0] == assa_pkg::SWT_KEY
    |-> ##[1:4] scan_busy_out) else $error("firmware trigger did not start a scan");
  start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
    else $error("conversion start longer than one cycle");
  start_in_scan_a: assert property (conv_start_out |-> scan_busy_out)
    else $error("conversion started outside a scan");
  complete_pulse_a: assert property (conv_complete_out |=> !conv_complete_out)
    else $error("complete pulse longer than one cycle");
  ref_stable_a: assert property (!$past(avs_write_in && done_acc)
    |-> $stable({conv_ref_external_out, conv_ref_low_out})) else $error("reference moved alone");
  unmapped_zero_a: assert property (avs_read_in && done_acc && avs_address_in >= 8'h40
    |-> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  queue_count_a: assert property (avs_read_in && done_acc
    && avs_address_in == assa_pkg::QUEUE_OFS
    |-> (avs_readdata_out[27:20] <= 8'h10) && !avs_readdata_out[31])
    else $error("queue word count out of range");
  cover property (avs_write_in && done_acc && avs_address_in == assa_pkg::SWT_OFS);
  cover property (avs_read_in && done_acc && avs_address_in == assa_pkg::QUEUE_OFS);
  cover property (conv_complete_out);
endmodule : assa_top_checker
bind assa_top assa_top_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .conv_start_out(conv_start_out), .conv_ref_external_out(conv_ref_external_out),
  .conv_ref_low_out(conv_ref_low_out), .conv_complete_out(conv_complete_out),
  .scan_busy_out(scan_busy_out));

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] pin_trig = 4'h0;
  logic vcomp = 1'b0;
  logic tick = 1'b0;
  logic slow = 1'b0;
  logic [13:0] sample_val = 14'h0000;
  logic [31:0] rdata;
  logic waitreq, conv_start, conv_done, conv_complete, scan_busy, ref_ext, ref_low;
  logic [3:0] conv_chan;
  logic [3:0] exp_chan = 4'h0;
  logic [1:0] conv_prec;
  logic [13:0] conv_data;
  logic [31:0] exp_q[$];
  logic [31:0] lfsr_state = 32'h2385;
  logic [13:0] fill_s [17];
  int fail_count = 0;
  int checks_done = 0;
  always #5 clk_in = ~clk_in;
  assa_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .pin_trigger_in(pin_trig),
    .vcomp_trigger_in(vcomp), .timer3_tick_in(tick), .conv_start_out(conv_start),
    .conv_channel_out(conv_chan), .conv_precision_out(conv_prec),
    .conv_ref_external_out(ref_ext), .conv_ref_low_out(ref_low), .conv_done_in(conv_done),
    .conv_data_in(conv_data), .conv_complete_out(conv_complete), .scan_busy_out(scan_busy));
  assa_conv_model u_conv (.clk_in(clk_in), .rst_b_in(rst_b_in), .conv_start_in(conv_start),
    .slow_in(slow), .sample_in(sample_val), .conv_done_out(conv_done),
    .conv_data_out(conv_data));
  // ***************************************************
  // Checking helpers
  // ***************************************************
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  // Read data is taken at the completing edge, in the order reads were issued
  always @(posedge clk_in) begin
    if (rd && waitreq === 1'b0) check("readdata", exp_q.pop_front(), rdata);
    if (conv_start === 1'b1) check("channel", {28'h0, exp_chan}, {28'h0, conv_chan});
  end
  function automatic logic [31:0] qword(input logic [7:0] cnt, input logic [13:0] s);
    return {1'b0, 3'h0, cnt, s, 6'h00};
  endfunction : qword
  function automatic logic [13:0] next_sample();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state[13:0];
  endfunction : next_sample
  // ***************************************************
  // Bus and trigger tasks
  // ***************************************************
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    do @(posedge clk_in); while (waitreq !== 1'b0);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    do @(posedge clk_in); while (waitreq !== 1'b0);
    rd <= 1'b0;
  endtask : bus_rd
  // Busy may rise a few cycles late after pin synchronisers
  task automatic wait_scan();
    int n;
    n = 0;
    while (scan_busy !== 1'b1 && n < 30) begin
      @(posedge clk_in);
      n++;
    end
    while (scan_busy !== 1'b0) @(posedge clk_in);
  endtask : wait_scan
  task automatic trig_sw();
    bus_wr(assa_pkg::SWT_OFS, 32'h0000_0037);
    wait_scan();
  endtask : trig_sw
  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    bus_rd(assa_pkg::CFG_OFS, assa_pkg::CFG_RESET);
    bus_rd(assa_pkg::SLOT_BASE_OFS, assa_pkg::SLOT_RESET);
    bus_rd(8'h40, 32'h0000_0000);
    bus_wr(assa_pkg::CFG_OFS, 32'h0000_0371);
    @(negedge clk_in);
    check("reference", 32'h3, {30'h0, ref_ext, ref_low});
    bus_wr(assa_pkg::SLOT_BASE_OFS + 8'h04, 32'h0009_0000);
    // Every accumulation exponent, one result per 2^e scans
    for (int e = 0; e < 8; e++) begin
      exp_chan = e[3:0];
      slow = e[0];
      sample_val = next_sample();
      bus_wr(assa_pkg::SLOT_BASE_OFS, {5'h0, e[2:0], 4'h0, e[3:0], 16'h0001});
      repeat (1 << e) trig_sw();
      bus_rd(assa_pkg::QUEUE_OFS, qword(8'h01, sample_val));
      bus_rd(assa_pkg::QUEUE_OFS, qword(8'h01, sample_val));
      bus_wr(assa_pkg::QUEUE_OFS, 32'h0000_0000);
    end
    // Hardware trigger codes with rising polarity
    exp_chan = 4'h3;
    bus_wr(assa_pkg::SLOT_BASE_OFS, 32'h0003_0001);
    for (int c = 0; c < 5; c++) begin
      sample_val = next_sample();
      bus_wr(assa_pkg::CFG_OFS, {25'h0, c[2:0], 4'h1});
      if (c < 4) pin_trig[c] <= 1'b1;
      else vcomp <= 1'b1;
      wait_scan();
      pin_trig <= 4'h0;
      vcomp <= 1'b0;
      repeat (10) @(posedge clk_in);
      bus_rd(assa_pkg::QUEUE_OFS, qword(8'h01, sample_val));
      bus_wr(assa_pkg::QUEUE_OFS, 32'h0000_0000);
    end
    // Firmware source selected: pin and comparator edges ignored
    bus_wr(assa_pkg::CFG_OFS, 32'h0000_0071);
    pin_trig <= 4'hf;
    vcomp <= 1'b1;
    repeat (20) @(posedge clk_in);
    pin_trig <= 4'h0;
    vcomp <= 1'b0;
    repeat (20) @(posedge clk_in);
    trig_sw();
    bus_rd(assa_pkg::QUEUE_OFS, qword(8'h01, sample_val));
    bus_wr(assa_pkg::QUEUE_OFS, 32'h0000_0000);
    // Falling polarity: rising edge must not start, falling edge must
    bus_wr(assa_pkg::CFG_OFS, 32'h0000_0003);
    pin_trig[0] <= 1'b1;
    repeat (20) @(posedge clk_in);
    pin_trig[0] <= 1'b0;
    wait_scan();
    bus_rd(assa_pkg::QUEUE_OFS, qword(8'h01, sample_val));
    bus_wr(assa_pkg::QUEUE_OFS, 32'h0000_0000);
    // Repeat mode: firmware first, then timer ticks
    bus_wr(assa_pkg::CFG_OFS, 32'h0000_0075);
    trig_sw();
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_in);
      tick <= 1'b1;
      @(posedge clk_in);
      tick <= 1'b0;
      wait_scan();
    end
    bus_rd(assa_pkg::QUEUE_OFS, qword(8'h03, sample_val));
    bus_wr(assa_pkg::CFG_OFS, 32'h0000_0000);
    // Fill to sixteen, one more held off, then drain in order
    bus_wr(assa_pkg::CFG_OFS, 32'h0000_0071);
    bus_wr(assa_pkg::STAT_OFS, 32'h0000_0006);
    for (int k = 0; k < 16; k++) begin
      fill_s[k] = next_sample();
      sample_val = fill_s[k];
      trig_sw();
    end
    bus_rd(assa_pkg::STAT_OFS, 32'h0000_0016);
    fill_s[16] = next_sample();
    sample_val = fill_s[16];
    bus_wr(assa_pkg::SWT_OFS, 32'h0000_0037);
    repeat (40) @(posedge clk_in);
    bus_rd(assa_pkg::QUEUE_OFS, qword(8'h10, fill_s[0]));
    bus_wr(assa_pkg::QUEUE_OFS, 32'h0000_0000);
    repeat (10) @(posedge clk_in);
    for (int k = 1; k < 17; k++) begin
      bus_rd(assa_pkg::QUEUE_OFS, qword(8'(17 - k), fill_s[k]));
      bus_wr(assa_pkg::QUEUE_OFS, 32'h0000_0000);
    end
    summarize();
  end
  // Hang guard; full run needs well under this
  initial begin
    repeat (60000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
endmodule : testbench
